/* design/cdap_fifo_if.sv */
// link between the register front end and the sample buffer
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface cdap_fifo_if;
    logic                  push;
    cdap_pkg::cdap_sample_t pushData;
    logic                  pop;
    cdap_pkg::cdap_sample_t popData;
    logic                  flush;
    logic                  full;
    logic                  empty;
    modport owner (output push, pushData, pop, flush,
                   input popData, full, empty);
    modport store (input push, pushData, pop, flush,
                   output popData, full, empty);
endinterface

/* design/cdap_pkg.sv */
// types shared by the speaker modulator control files
// assumes nothing beyond a SystemVerilog compiler
package cdap_pkg;
    typedef logic [31:0] cdap_word_t;
    typedef logic [7:0]  cdap_addr_t;
    typedef logic [15:0] cdap_sample_t;
    typedef enum logic [1:0] {
        CDAP_DITH_NONE = 2'h0,
        CDAP_DITH_ONE  = 2'h1,
        CDAP_DITH_ALT  = 2'h2,
        CDAP_DITH_TWO  = 2'h3
    } cdap_dither_e;
endpackage

/* design/cdap_regs.svh */
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the speaker modulator design files
`ifndef CDAP_REGS_SVH
`define CDAP_REGS_SVH
`define CDAP_OFS_CTRL   8'h00
`define CDAP_OFS_STAT   8'h04
`define CDAP_OFS_DMA    8'h08
`define CDAP_OFS_DATA   8'h0C
`define CDAP_OFS_HDIV   8'h10
`define CDAP_CTRL_RST   7'h00
`define CDAP_DMA_RST    1'h0
`define CDAP_HDIV_RST   8'h30
`define CDAP_BIT_EN     6
`define CDAP_DITH_HI    5
`define CDAP_DITH_LO    4
`define CDAP_BIT_DEAD   3
`define CDAP_RATE_HI    2
`define CDAP_STAT_EMPTY 1
`define CDAP_STAT_FULL  0
`define CDAP_OVERSAMPLE 14'h0040
`define CDAP_DIV0       10'h0E4
`define CDAP_DIV1       10'h09C
`define CDAP_DIV2       10'h04C
`define CDAP_DIV3       10'h034
`define CDAP_DIV4       10'h30C
`define CDAP_DIV5       10'h20C
`define CDAP_DIV6       10'h18C
`define CDAP_DIV7       10'h10C
`endif

/* design/cdap_sample_fifo.sv */
// sixteen-entry sample buffer with pointer flush
// assumes synchronous reset copy from the top and one clock
`timescale 1ns/100ps
module cdap_sample_fifo #(
    parameter int AW = 4
) (
    input wire logic   clock,
    input wire logic   rstSyncB,
    cdap_fifo_if.store fifo
);
    import cdap_pkg::*;

    cdap_sample_t  mem [2**AW];
    logic [AW:0]   wrPtr_r;
    logic [AW:0]   rdPtr_r;
    logic          doPush;
    logic          doPop;

    // flags come straight from the pointers [R16]
    assign fifo.full  = (wrPtr_r[AW] != rdPtr_r[AW]) &&
                        (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
    assign fifo.empty = (wrPtr_r == rdPtr_r);
    assign fifo.popData = mem[rdPtr_r[AW-1:0]];
    assign doPush = fifo.push && !fifo.full; // [R17]
    assign doPop  = fifo.pop && !fifo.empty;

    // contents are never cleared, only the pointers [R2]
    always_ff @(posedge clock) begin
        if (doPush) begin
            mem[wrPtr_r[AW-1:0]] <= fifo.pushData; // [R12]
        end
    end

    always_ff @(posedge clock or negedge rstSyncB) begin
        if (!rstSyncB) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
        end else if (fifo.flush) begin
            wrPtr_r <= '0; // [R2]
            rdPtr_r <= '0;
        end else begin
            if (doPush) begin
                wrPtr_r <= wrPtr_r + 1'b1; // [R12]
            end
            if (doPop) begin
                rdPtr_r <= rdPtr_r + 1'b1;
            end
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rstSyncB);

    a_push_advance: assert property (doPush && !doPop && !fifo.flush
        |=> wrPtr_r - rdPtr_r == $past(wrPtr_r - rdPtr_r) + 1'b1) // [R12]
        else $error("accepted write did not advance the buffer");
    a_full_drop: assert property (fifo.push && fifo.full && !fifo.pop
        && !fifo.flush |=> fifo.full) // [R17]
        else $error("write into a full buffer was not dropped");
    a_flush_empty: assert property (fifo.flush |=> fifo.empty) // [R2]
        else $error("flush left the buffer pointers apart");
    c_fill_up: cover property (fifo.push ##1 fifo.full);
endmodule

/* design/cdap_speaker_pwm.sv */
// register front end and carrier modulator for a bridge-tied speaker
// assumes one 25 MHz clock shared with the register master and dma
//
// Notes on behaviour
// R1: disabled: both speaker pins released, interpolation hold cleared
// R2: disabling flushes buffer pointers, stored samples stay
// R3: enabled: both speaker pins driven, samples taken from the buffer
// R4: dither code 0 none, 1 plus/minus one, 3 plus/minus two
// R5: deadtime bit adds one released cycle around each switch
// R6: rate codes 0..3 give carrier divisors 228, 156, 76, 52
// R7: rate codes 4..7 give carrier divisors 780, 524, 396, 268
// R8: control register at 0x00, resets to zero, block disabled
// R9: status register read only at 0x04, resets to empty
// R10: hold divisor at 0x10, read/write, resets to 0x30
// R11: dma control read/write at 0x08; sample port write only at 0x0C
// R12: each sample port write pushes low sixteen bits
// R13: status bit 1 is empty, bit 0 is full
// R14: sample rate is clock over hold divisor over 64; divisor 1..255
// R15: dma request while dma control bit 0 is set and the buffer has free space
// R16: sixteen-entry buffer, flags from its pointers
// R17: writes into a full buffer are dropped
`timescale 1ns/100ps
`include "cdap_regs.svh"
module cdap_speaker_pwm #(
    parameter int FIFO_AW = 4
) (
    input  wire logic              clock,
    input  wire logic              rst_b,
    input  wire cdap_pkg::cdap_addr_t regAddr,
    input  wire cdap_pkg::cdap_word_t regWrData,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    output cdap_pkg::cdap_word_t   regRdData,
    output logic                   dmaReq,
    output logic                   spkPos,
    output logic                   spkPosOeB,
    output logic                   spkNeg,
    output logic                   spkNegOeB
);
    import cdap_pkg::*;

    logic [1:0]   rstPipe_r;
    logic         rstSyncB;
    logic [6:0]   ctrl_r;
    logic         dma_request_enable_r;
    logic [7:0]   holdDiv_r;
    cdap_word_t   rdData_r;
    logic         modEn;
    logic         deadEn;
    cdap_dither_e ditherSel;
    logic [9:0]   period;
    logic [13:0]  holdCnt_r;
    logic [13:0]  holdLimit;
    logic         sampleTick;
    cdap_sample_t held_r;
    logic [9:0]   carCnt_r;
    logic         periodEnd;
    logic [25:0]  product;
    logic [9:0]   dutyRaw;
    logic signed [11:0] dither;
    logic signed [11:0] dutySum;
    logic [9:0]   dutyNxt;
    logic [9:0]   duty_r;
    logic [7:0]   lfsr_r;
    logic         pwmNow;
    logic         pwmOut_r;
    logic         release_r;

    cdap_fifo_if  fifoBus ();

    cdap_sample_fifo #(
        .AW       (FIFO_AW)
    ) i_cdap_sample_fifo (
        .clock    (clock),
        .rstSyncB (rstSyncB),
        .fifo     (fifoBus)
    );

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rstPipe_r <= 2'h0;
        end else begin
            rstPipe_r <= {rstPipe_r[0], 1'b1};
        end
    end
    assign rstSyncB = rstPipe_r[1];

    assign modEn     = ctrl_r[`CDAP_BIT_EN];
    assign deadEn    = ctrl_r[`CDAP_BIT_DEAD];
    assign ditherSel = cdap_dither_e'(ctrl_r[`CDAP_DITH_HI:`CDAP_DITH_LO]);

    // control register [R8]
    always_ff @(posedge clock or negedge rstSyncB) begin
        if (!rstSyncB) begin
            ctrl_r <= `CDAP_CTRL_RST; // [R8]
        end else if (regWrite && regAddr == `CDAP_OFS_CTRL) begin
            ctrl_r <= regWrData[6:0];
        end
    end

    always_ff @(posedge clock or negedge rstSyncB) begin
        if (!rstSyncB) begin
            dma_request_enable_r <= `CDAP_DMA_RST; // [R11]
        end else if (regWrite && regAddr == `CDAP_OFS_DMA) begin
            dma_request_enable_r <= regWrData[0];
        end
    end

    always_ff @(posedge clock or negedge rstSyncB) begin
        if (!rstSyncB) begin
            holdDiv_r <= `CDAP_HDIV_RST; // [R10]
        end else if (regWrite && regAddr == `CDAP_OFS_HDIV) begin
            holdDiv_r <= regWrData[7:0];
        end
    end

    // read data stand for exactly the cycle after the strobe
    always_ff @(posedge clock or negedge rstSyncB) begin
        if (!rstSyncB) begin
            rdData_r <= 32'h0000_0000;
        end else if (regRead) begin
            unique case (regAddr)
                `CDAP_OFS_CTRL: rdData_r <= {25'h0, ctrl_r};
                `CDAP_OFS_STAT: rdData_r <= {30'h0, fifoBus.empty,
                                             fifoBus.full}; // [R9] [R13]
                `CDAP_OFS_DMA:  rdData_r <= {31'h0, dma_request_enable_r}; // [R11]
                `CDAP_OFS_HDIV: rdData_r <= {24'h0, holdDiv_r}; // [R10]
                default:        rdData_r <= 32'h0000_0000;
            endcase
        end else begin
            rdData_r <= 32'h0000_0000;
        end
    end
    assign regRdData = rdData_r;

    // sample port is write only and reads back zero [R11]
    assign fifoBus.push     = regWrite && regAddr == `CDAP_OFS_DATA; // [R12]
    assign fifoBus.pushData = regWrData[15:0]; // [R12]
    assign fifoBus.flush    = !modEn; // [R2]
    assign fifoBus.pop      = modEn && sampleTick; // [R3]

    // level request; the dma sees it drop the cycle after the last slot
    assign dmaReq = dma_request_enable_r && !fifoBus.full; // [R15]

    // a zero divisor would stall sampling, so it behaves as one [R14]
    assign holdLimit = (holdDiv_r == 8'h00)
        ? `CDAP_OVERSAMPLE - 14'h0001
        : 14'(holdDiv_r * `CDAP_OVERSAMPLE) - 14'h0001;
    assign sampleTick = (holdCnt_r >= holdLimit);

    always_ff @(posedge clock or negedge rstSyncB) begin
        if (!rstSyncB) begin
            holdCnt_r <= 14'h0000;
        end else if (!modEn || sampleTick) begin
            holdCnt_r <= 14'h0000; // [R14]
        end else begin
            holdCnt_r <= holdCnt_r + 14'h0001;
        end
    end

    // zero-order hold stands in for the interpolator; an empty buffer
    // repeats the last sample rather than jumping to silence
    always_ff @(posedge clock or negedge rstSyncB) begin
        if (!rstSyncB) begin
            held_r <= 16'h0000;
        end else if (!modEn) begin
            held_r <= 16'h0000; // [R1]
        end else if (sampleTick && !fifoBus.empty) begin
            held_r <= fifoBus.popData; // [R3]
        end
    end

    always_comb begin
        unique case (ctrl_r[`CDAP_RATE_HI:0])
            3'h0: period = `CDAP_DIV0; // [R6]
            3'h1: period = `CDAP_DIV1;
            3'h2: period = `CDAP_DIV2;
            3'h3: period = `CDAP_DIV3;
            3'h4: period = `CDAP_DIV4; // [R7]
            3'h5: period = `CDAP_DIV5;
            3'h6: period = `CDAP_DIV6;
            3'h7: period = `CDAP_DIV7;
        endcase
    end

    // a rate change mid-period takes effect at once; the counter never runs past the new wrap
    assign periodEnd = (carCnt_r >= period - 10'h001);

    always_ff @(posedge clock or negedge rstSyncB) begin
        if (!rstSyncB) begin
            carCnt_r <= 10'h000;
        end else if (!modEn || periodEnd) begin
            carCnt_r <= 10'h000; // [R6] [R7]
        end else begin
            carCnt_r <= carCnt_r + 10'h001;
        end
    end

    always_ff @(posedge clock or negedge rstSyncB) begin
        if (!rstSyncB) begin
            lfsr_r <= 8'h01;
        end else if (periodEnd) begin
            lfsr_r <= {lfsr_r[6:0],
                       lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
        end
    end

    // offset binary sample scaled onto the carrier period
    assign product = 26'({held_r[15] ^ 1'b1, held_r[14:0]} * period);
    assign dutyRaw = product[25:16];

    // code 2 is treated like code 1
    always_comb begin
        unique case (ditherSel)
            CDAP_DITH_NONE: dither = 12'sh000; // [R4]
            CDAP_DITH_ONE,
            CDAP_DITH_ALT:  dither = lfsr_r[0] ? 12'sh001 : -12'sh001;
            CDAP_DITH_TWO:  dither = lfsr_r[1]
                ? (lfsr_r[0] ? 12'sh002 : 12'sh001)
                : (lfsr_r[0] ? -12'sh002 : -12'sh001); // [R4]
        endcase
    end

    assign dutySum = $signed({2'h0, dutyRaw}) + dither;

    always_comb begin
        if (dutySum < 12'sh000) begin
            dutyNxt = 10'h000;
        end else if (dutySum > $signed({2'h0, period})) begin
            dutyNxt = period;
        end else begin
            dutyNxt = dutySum[9:0];
        end
    end

    always_ff @(posedge clock or negedge rstSyncB) begin
        if (!rstSyncB) begin
            duty_r <= 10'h000;
        end else if (periodEnd) begin
            duty_r <= dutyNxt; // [R4]
        end
    end

    assign pwmNow = modEn && (carCnt_r < duty_r);

    always_ff @(posedge clock or negedge rstSyncB) begin
        if (!rstSyncB) begin
            pwmOut_r <= 1'b0;
        end else begin
            pwmOut_r <= pwmNow;
        end
    end

    // release both legs for one cycle on each edge so neither
    // transistor pair conducts through the bridge
    always_ff @(posedge clock or negedge rstSyncB) begin
        if (!rstSyncB) begin
            release_r <= 1'b1;
        end else begin
            release_r <= !modEn // [R1] [R3]
                || (deadEn && pwmNow != pwmOut_r); // [R5]
        end
    end

    assign spkPos    = pwmOut_r;
    assign spkNeg    = !pwmOut_r;
    assign spkPosOeB = release_r;
    assign spkNegOeB = release_r;

    default clocking @(posedge clock); endclocking
    default disable iff (!rstSyncB);

    a_off_release: assert property (!modEn |=> spkPosOeB && spkNegOeB
        && held_r == 16'h0000) // [R1]
        else $error("disabled block still drives the speaker");
    a_flush_on_off: assert property (!modEn |=> fifoBus.empty) // [R2]
        else $error("disable did not flush buffer pointers");
    a_on_drive: assert property (modEn && !deadEn ##1 modEn && !deadEn
        |=> !spkPosOeB && !spkNegOeB && spkNeg == !spkPos) // [R3]
        else $error("enabled block not driving both legs");
    a_no_dither: assert property (periodEnd && ditherSel == CDAP_DITH_NONE
        |=> duty_r == $past(dutyRaw)) // [R4]
        else $error("duty moved with dither off");
    a_two_dither: assert property (periodEnd && ditherSel == CDAP_DITH_TWO
        && dutyRaw > 10'h002 && dutyRaw < period - 10'h002
        |=> duty_r != $past(dutyRaw)) // [R4]
        else $error("two-bit dither left duty unchanged");
    a_dead_gap: assert property (modEn && deadEn && $past(deadEn) && $past(modEn)
        && spkPos != $past(spkPos) |-> spkPosOeB) // [R5]
        else $error("leg switched without a released cycle");
    a_car_wrap: assert property (periodEnd && modEn
        && ctrl_r[`CDAP_RATE_HI:0] == 3'h3 |-> carCnt_r == 10'h033) // [R6]
        else $error("carrier wrap at the wrong count");
    a_car_slow: assert property (periodEnd && modEn
        && ctrl_r[`CDAP_RATE_HI:0] == 3'h4 |-> carCnt_r == 10'h30B) // [R7]
        else $error("slow carrier wrap at the wrong count");
    a_stat_read: assert property (regRead && regAddr == `CDAP_OFS_STAT
        |=> regRdData[1:0] == $past({fifoBus.empty, fifoBus.full})) // [R13]
        else $error("status read does not match buffer flags");
    a_data_wo: assert property (regRead && regAddr == `CDAP_OFS_DATA
        |=> regRdData == 32'h0000_0000) // [R11]
        else $error("sample port read back nonzero");
    a_dma_full: assert property (fifoBus.full |-> !dmaReq) // [R15]
        else $error("dma asked for data into a full buffer");
    a_hold_tick: assert property (modEn && holdDiv_r == 8'h01
        && sampleTick ##1 modEn && holdDiv_r == 8'h01
        |-> !sampleTick) // [R14]
        else $error("hold tick came too early");

    c_dead_seen: cover property (modEn && deadEn && spkPosOeB ##1
        !spkPosOeB);
    c_sample_pop: cover property (fifoBus.pop && !fifoBus.empty);
    c_dma_stop: cover property (dmaReq ##1 !dmaReq);
endmodule

/* dv/cdap_dma_model.sv */
// dma controller model feeding the sample port while requested
// assumes the bench muxes its strobe onto the register bus when go is high
`timescale 1ns/100ps
module cdap_dma_model (
    input  wire logic           clock,
    input  wire logic           rstB,
    input  wire logic           go,
    input  wire logic [3:0]     gap,
    input  wire logic           dmaReq,
    output cdap_pkg::cdap_addr_t dAddr,
    output cdap_pkg::cdap_word_t dWrData,
    output logic                dWrite,
    output logic [7:0]          sent
);
    import cdap_pkg::*;
    logic [3:0] waitCnt;
    assign dAddr = 8'h0C;
    // one write then an idle cycle, so the request level is seen after it
    always_ff @(posedge clock or negedge rstB) begin
        if (!rstB) begin
            dWrite  <= 1'b0;
            dWrData <= 32'h0;
            sent    <= 8'h00;
            waitCnt <= 4'h0;
        end else if (!go || dWrite) begin
            // stale data is scrambled once the strobe is gone
            if (dWrite) dWrData <= ~dWrData;
            dWrite  <= 1'b0;
            waitCnt <= gap;
        end else if (waitCnt != 4'h0) begin
            waitCnt <= waitCnt - 4'h1;
        end else if (dmaReq) begin
            dWrite  <= 1'b1;
            dWrData <= 32'h0000A000 + {24'h0, sent};
            sent    <= sent + 8'h01;
        end
    end
endmodule

/* dv/cdap_speaker_pwm_bench.sv */
// self-checking bench for the speaker modulator control block
// assumes a 25 MHz clock and the dma model sharing the register bus
`timescale 1ns/100ps
`include "cdap_regs.svh"
module cdap_speaker_pwm_bench;
    import cdap_pkg::*;
    logic       clock, rst_b, bWr, bRd, dWr, dmaGo, dmaReq;
    logic       spkPos, spkPosOeB, spkNeg, spkNegOeB;
    cdap_addr_t bAddr, dAddr;
    cdap_word_t bWd, dWd, regRdData;
    logic [7:0] sent;
    logic [3:0] dmaGap;
    int         errCount, totalChecks;
    int         divs [8] = '{228, 156, 76, 52, 780, 524, 396, 268};

    cdap_speaker_pwm i_cdap_speaker_pwm (.clock(clock), .rst_b(rst_b),
        .regAddr(dmaGo ? dAddr : bAddr), .regWrData(dmaGo ? dWd : bWd),
        .regWrite(dmaGo ? dWr : bWr), .regRead(bRd),
        .regRdData(regRdData), .dmaReq(dmaReq), .spkPos(spkPos),
        .spkPosOeB(spkPosOeB), .spkNeg(spkNeg), .spkNegOeB(spkNegOeB));
    cdap_dma_model i_cdap_dma_model (.clock(clock), .rstB(rst_b),
        .go(dmaGo), .gap(dmaGap), .dmaReq(dmaReq), .dAddr(dAddr),
        .dWrData(dWd), .dWrite(dWr), .sent(sent));

    always #20 clock = ~clock;

    task automatic chk(input cdap_word_t seen, input cdap_word_t exp);
        totalChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input cdap_addr_t a, input cdap_word_t d);
        @(posedge clock);
        bAddr <= a;
        bWd   <= d;
        bWr   <= 1'b1;
        @(posedge clock);
        bWr   <= 1'b0;
    endtask

    task automatic rd(input cdap_addr_t a, input cdap_word_t exp);
        @(posedge clock);
        bAddr <= a;
        bRd   <= 1'b1;
        @(posedge clock);
        bRd   <= 1'b0;
        #1;
        chk(regRdData, exp);
    endtask

    task automatic test_reset;
        rd(`CDAP_OFS_CTRL, 32'h0);
        rd(`CDAP_OFS_STAT, 32'h2);
        rd(`CDAP_OFS_DMA, 32'h0);
        rd(`CDAP_OFS_DATA, 32'h0);
        rd(`CDAP_OFS_HDIV, 32'h30);
        rd(8'h14, 32'h0);
        chk({spkPosOeB, spkNegOeB, dmaReq}, 32'h6);
        $display("test reset done");
    endtask

    task automatic test_access;
        wr(`CDAP_OFS_CTRL, 32'hFFFFFFBF);
        rd(`CDAP_OFS_CTRL, 32'h3F);
        for (int d = 0; d < 4; d++) begin
            wr(`CDAP_OFS_CTRL, 32'(d) << 4);
            rd(`CDAP_OFS_CTRL, 32'(d) << 4);
        end
        wr(`CDAP_OFS_STAT, 32'h0);
        rd(`CDAP_OFS_STAT, 32'h2);
        wr(`CDAP_OFS_DMA, 32'hFFFFFFFF);
        rd(`CDAP_OFS_DMA, 32'h1);
        chk(dmaReq, 32'h1);
        wr(`CDAP_OFS_HDIV, 32'h1FF);
        rd(`CDAP_OFS_HDIV, 32'hFF);
        // a sample written while disabled is flushed away
        wr(`CDAP_OFS_DATA, 32'h1234);
        rd(`CDAP_OFS_STAT, 32'h2);
        $display("test access done");
    endtask

    task automatic test_fill;
        wr(`CDAP_OFS_CTRL, 32'h40);
        // the legs are taken one edge after the enable lands
        @(posedge clock);
        #1;
        chk({spkPosOeB, spkNegOeB}, 32'h0);
        for (int i = 0; i < 17; i++) begin
            @(posedge clock);
            bAddr <= `CDAP_OFS_DATA;
            bWd   <= 32'hFFFF0000 + 32'(i);
            bWr   <= 1'b1;
        end
        @(posedge clock);
        bWr <= 1'b0;
        rd(`CDAP_OFS_STAT, 32'h1);
        chk(dmaReq, 32'h0);
        wr(`CDAP_OFS_CTRL, 32'h0);
        rd(`CDAP_OFS_STAT, 32'h2);
        chk({spkPosOeB, spkNegOeB}, 32'h3);
        $display("test fill done");
    endtask

    task automatic test_dma;
        int n;
        wr(`CDAP_OFS_CTRL, 32'h40);
        @(posedge clock);
        dmaGo <= 1'b1;
        for (n = 0; n < 200 && dmaReq !== 1'b0; n++) begin
            @(posedge clock);
            #1;
        end
        @(posedge clock);
        dmaGo <= 1'b0;
        chk(32'(sent), 32'd16);
        rd(`CDAP_OFS_STAT, 32'h1);
        wr(`CDAP_OFS_CTRL, 32'h0);
        wr(`CDAP_OFS_DMA, 32'h0);
        #1;
        chk(dmaReq, 32'h0);
        $display("test dma done");
    endtask

    // at a divisor of one the sample leaves the buffer 64 cycles after enable
    task automatic test_hold;
        int   hi, rises;
        logic prev;
        wr(`CDAP_OFS_HDIV, 32'h1);
        wr(`CDAP_OFS_CTRL, 32'h73);
        @(posedge clock);
        bAddr <= `CDAP_OFS_DATA;
        bWd   <= 32'h80004000;
        bWr   <= 1'b1;
        @(posedge clock);
        bWr   <= 1'b0;
        bAddr <= `CDAP_OFS_STAT;
        bRd   <= 1'b1;
        @(posedge clock);
        bRd   <= 1'b0;
        #1;
        chk(regRdData, 32'h0);
        repeat (60) @(posedge clock);
        bRd   <= 1'b1;
        @(posedge clock);
        #1;
        chk(regRdData, 32'h0);
        @(posedge clock);
        bRd   <= 1'b0;
        #1;
        chk(regRdData, 32'h2);
        // low half 0x4000 gives 39 of 52; code 3 never adds zero
        hi = 0;
        rises = 0;
        prev = spkPos;
        for (int i = 0; i < 400 && rises < 3; i++) begin
            @(posedge clock);
            #1;
            if (spkPos === 1'b1 && prev === 1'b0) rises++;
            if (rises == 2 && spkPos === 1'b1) hi++;
            prev = spkPos;
        end
        chk(32'(rises), 32'd3);
        chk(32'(hi > 36 && hi < 42 && hi != 39), 32'h1);
        wr(`CDAP_OFS_CTRL, 32'h0);
        $display("test hold done");
    endtask

    // empty buffer holds midscale, so the high time is half the period
    task automatic carrier(input logic [2:0] code, input logic dead);
        int   n, hi, rises;
        logic prev;
        wr(`CDAP_OFS_CTRL, {25'h0, 1'b1, 2'h0, dead, code});
        n = 0;
        hi = 0;
        rises = 0;
        #1;
        prev = spkPos;
        for (int i = 0; i < 4000 && rises < 3; i++) begin
            @(posedge clock);
            #1;
            if (spkPos !== prev)
                chk({spkPosOeB, spkNegOeB, spkNeg ^ spkPos},
                    {29'h0, dead, dead, 1'b1});
            if (spkPos === 1'b1 && prev === 1'b0) rises++;
            if (rises == 2) begin
                n++;
                hi += (spkPos === 1'b1) ? 1 : 0;
            end
            prev = spkPos;
        end
        chk(32'(n), 32'(divs[code]));
        if (!dead) chk(32'(hi), 32'(divs[code] / 2));
    endtask

    task automatic test_carrier;
        for (int c = 0; c < 8; c++) carrier(3'(c), 1'b0);
        carrier(3'h3, 1'b1);
        wr(`CDAP_OFS_CTRL, 32'h0);
        $display("test carrier done");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        rst_b = 1'b0;
        bAddr = 8'h00;
        bWd = 32'h0;
        bWr = 1'b0;
        bRd = 1'b0;
        dmaGo = 1'b0;
        dmaGap = 4'h0;
        errCount = 0;
        totalChecks = 0;
        repeat (5) @(posedge clock);
        rst_b <= 1'b1;
        repeat (3) @(posedge clock);
        test_reset();
        test_access();
        test_fill();
        test_dma();
        test_hold();
        test_carrier();
        results();
    end

    // the tests need about 10000 cycles; allow several times that
    initial begin
        #(40 * 60000);
        errCount++;
        results();
    end
endmodule
